// >>> hdl/pfc_pkg.sv
// Package: register map, reset values and pin drive carrier for the port
package pfc_pkg;

   // Register byte addresses
   localparam logic [15:0] ADDR_DATA     = 16'hF278;
   localparam logic [15:0] ADDR_DIR      = 16'hF279;
   localparam logic [15:0] ADDR_CFG_LOW  = 16'hF27A;
   localparam logic [15:0] ADDR_CFG_HIGH = 16'hF27B;

   // Reset values
   localparam logic [7:0]  RST_DATA      = 8'h00;
   localparam logic [7:0]  RST_DIR       = 8'h00;
   localparam logic [7:0]  RST_CFG_LOW   = 8'h00;
   localparam logic [7:0]  RST_CFG_HIGH  = 8'h00;
   localparam logic [15:0] RDATA_NONE    = 16'h0000;
   localparam logic [7:0]  RST_PADS      = 8'h00;

   // Direction bit values
   localparam logic        DIR_OUTPUT    = 1'h0;
   localparam logic        DIR_INPUT     = 1'h1;

   // Number of pins in the port
   localparam int          PIN_COUNT     = 8;

   // Per-pin configuration codes {high bit, low bit}
   typedef enum logic [1:0] {
      CODE_HIZ  = 2'b00,
      CODE_PCH  = 2'b01,
      CODE_NCH  = 2'b10,
      CODE_CMOS = 2'b11
   } pfc_code_t;

   // What one pin cell asks of its pad
   typedef struct packed {
      logic out;
      logic oe;
      logic pull_up;
      logic pull_dn;
   } pfc_drive_t;

endpackage : pfc_pkg

// >>> hdl/pfc_pin_cell.sv
// Pin cell: decodes one pin's code, direction and data into pad controls
`timescale 1ns/1ps
`default_nettype none

module pfc_pin_cell
(
   // Pin configuration
   input  wire logic             i_dir,
   input  wire logic             i_cfg_low,
   input  wire logic             i_cfg_high,
   input  wire logic             i_data,
   // Pad controls
   output pfc_pkg::pfc_drive_t   o_drive
);

   wire pfc_pkg::pfc_code_t code;
   wire logic               is_out;
   wire logic               drv_out;
   wire logic               drv_oe;
   wire logic               drv_up;
   wire logic               drv_dn;

   // Code bit 1 from the high register, bit 0 from the low register
   assign code   = pfc_pkg::pfc_code_t'({i_cfg_high, i_cfg_low});   // [RULE8]
   assign is_out = (i_dir == pfc_pkg::DIR_OUTPUT);                  // [RULE4]

   // Output mode drive; P-channel only pulls high, N-channel only low
   assign drv_oe = is_out &&                                        // [RULE1]
      ((code == pfc_pkg::CODE_CMOS) ||
       ((code == pfc_pkg::CODE_PCH) &&  i_data) ||                  // [RULE10]
       ((code == pfc_pkg::CODE_NCH) && !i_data));                   // [RULE10]
   assign drv_out = (code == pfc_pkg::CODE_CMOS) ? i_data :         // [RULE9]
                    (code == pfc_pkg::CODE_PCH);

   // Input mode pulls; code 11 falls back to plain high impedance
   assign drv_dn = !is_out && (code == pfc_pkg::CODE_PCH);          // [RULE2]
   assign drv_up = !is_out && (code == pfc_pkg::CODE_NCH);  // [RULE2] [RULE3]

   // One driver for the whole carrier, so no field has a second source
   assign o_drive = '{out:     drv_out,
                      oe:      drv_oe,
                      pull_up: drv_up,
                      pull_dn: drv_dn};

endmodule : pfc_pin_cell

`default_nettype wire

// >>> hdl/pfc_port.sv
// Port top: pin drive and pull configuration registers with pad control
//
// Function
// [RULE1] An output-mode pin drives high-Z, P open drain, N open drain or push-pull for codes 00 to 11.
// [RULE2] An input-mode pin is high-Z for 00, pulled down for 01 and pulled up for 10.
// [RULE3] An input-mode pin with code 11 behaves as code 00, with no pull at all.
// [RULE4] Each pin's code is read as drive or pull choice according to its own direction bit.
// [RULE5] Both configuration registers clear to zero at reset, so every pin starts high-Z output.
// [RULE6] The low configuration register sits at F27A, is read/write and takes byte or word access.
// [RULE7] The high configuration register sits at F27B, is read/write and takes byte access.
// [RULE8] Bit n of the high and low registers together form pin n's code only.
// [RULE9] Output pins follow the data register; in input mode data reads return pin levels.
// [RULE10] P open drain drives only a 1 high, N open drain drives only a 0 low, else floats.
`timescale 1ns/1ps
`default_nettype none

module pfc_port
(
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   // Register port
   input  wire logic [15:0] i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic        i_wide,
   output logic      [15:0] o_rdata,
   // Pads
   input  wire logic [7:0]  i_pin_in,
   output logic      [7:0]  o_pin_out,
   output logic      [7:0]  o_pin_oe,
   output logic      [7:0]  o_pull_up,
   output logic      [7:0]  o_pull_dn
);

   logic [7:0]  data_ff;
   logic [7:0]  dir_ff;
   logic [7:0]  cfg_low_ff;
   logic [7:0]  cfg_high_ff;
   logic [15:0] rdata_ff;
   logic [7:0]  pin_out_ff;
   logic [7:0]  pin_oe_ff;
   logic [7:0]  pull_up_ff;
   logic [7:0]  pull_dn_ff;

   wire logic [7:0]  nxt_data;
   wire logic [7:0]  nxt_dir;
   wire logic [7:0]  nxt_cfg_low;
   wire logic [7:0]  nxt_cfg_high;
   wire logic [15:0] nxt_rdata;
   wire logic [7:0]  nxt_pin_out;
   wire logic [7:0]  nxt_pin_oe;
   wire logic [7:0]  nxt_pull_up;
   wire logic [7:0]  nxt_pull_dn;

   wire logic        hit_data;
   wire logic        hit_dir;
   wire logic        hit_low;
   wire logic        hit_high;
   wire logic        wide_low;
   wire logic        wr_data;
   wire logic        wr_dir;
   wire logic        wr_low;
   wire logic        wr_high_byte;
   wire logic        wr_high_word;
   wire logic [7:0]  data_view;
   wire logic [15:0] rd_word;
   wire logic [15:0] rd_low;
   wire logic [15:0] rd_high;
   wire logic [15:0] rd_data;
   wire logic [15:0] rd_dir;

   // Address decode; a word access is honoured only at the low register
   assign hit_data = (i_addr == pfc_pkg::ADDR_DATA);
   assign hit_dir  = (i_addr == pfc_pkg::ADDR_DIR);
   assign hit_low  = (i_addr == pfc_pkg::ADDR_CFG_LOW);             // [RULE6]
   assign hit_high = (i_addr == pfc_pkg::ADDR_CFG_HIGH);            // [RULE7]
   assign wide_low = hit_low && i_wide;                             // [RULE6]

   // Write enables, one per register byte lane, plus a word enable for the high byte
   assign wr_data      = i_wr && hit_data;
   assign wr_dir       = i_wr && hit_dir;
   assign wr_low       = i_wr && hit_low;                           // [RULE6]
   assign wr_high_byte = i_wr && hit_high;                          // [RULE7]
   assign wr_high_word = i_wr && wide_low;                          // [RULE6]

   // Next register values; a word write at the low address fills both
   assign nxt_data     = wr_data ? i_wdata[7:0] : data_ff;
   assign nxt_dir      = wr_dir  ? i_wdata[7:0] : dir_ff;
   assign nxt_cfg_low  = wr_low  ? i_wdata[7:0] : cfg_low_ff;
   assign nxt_cfg_high = wr_high_word ? i_wdata[15:8] :             // [RULE6]
                         wr_high_byte ? i_wdata[7:0] :              // [RULE7]
                         cfg_high_ff;

   // Input pins read back their level, output pins the stored bit
   assign data_view = (dir_ff & i_pin_in) | (~dir_ff & data_ff);    // [RULE9]

   // Read views of each register, byte views zero-extended to the bus width
   assign rd_word = {cfg_high_ff, cfg_low_ff};                      // [RULE8]
   assign rd_low  = {8'h00, cfg_low_ff};
   assign rd_high = {8'h00, cfg_high_ff};
   assign rd_data = {8'h00, data_view};
   assign rd_dir  = {8'h00, dir_ff};

   // Read mux; unmapped addresses and idle cycles answer zero, so a
   // read value never lingers on the bus beyond its one cycle
   assign nxt_rdata =
      !i_rd    ? pfc_pkg::RDATA_NONE :
      wide_low ? rd_word :                                          // [RULE6]
      hit_low  ? rd_low :
      hit_high ? rd_high :
      hit_data ? rd_data :
      hit_dir  ? rd_dir :
      pfc_pkg::RDATA_NONE;

   // One decode cell per pin, each seeing only its own bits
   genvar gi;
   generate
      for (gi = 0; gi < pfc_pkg::PIN_COUNT; gi = gi + 1)
      begin : g_pin
         pfc_pkg::pfc_drive_t drv;
         pfc_pin_cell u_cell
         (
            .i_dir      (dir_ff[gi]),                               // [RULE4]
            .i_cfg_low  (cfg_low_ff[gi]),                           // [RULE8]
            .i_cfg_high (cfg_high_ff[gi]),                          // [RULE8]
            .i_data     (data_ff[gi]),
            .o_drive    (drv)
         );
         assign nxt_pin_out[gi] = drv.out;
         assign nxt_pin_oe[gi]  = drv.oe;
         assign nxt_pull_up[gi] = drv.pull_up;
         assign nxt_pull_dn[gi] = drv.pull_dn;
      end
   endgenerate

   // Data register; only output-mode pins put it on the pad
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         data_ff <= pfc_pkg::RST_DATA;
      else
         data_ff <= nxt_data;
   end

   // Direction register; all pins start as outputs
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         dir_ff <= pfc_pkg::RST_DIR;
      else
         dir_ff <= nxt_dir;
   end

   // Low code bits; zero config means high-Z output at start
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         cfg_low_ff <= pfc_pkg::RST_CFG_LOW;                        // [RULE5]
      else
         cfg_low_ff <= nxt_cfg_low;
   end

   // High code bits; written by a byte here or a word at the low address
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         cfg_high_ff <= pfc_pkg::RST_CFG_HIGH;                      // [RULE5]
      else
         cfg_high_ff <= nxt_cfg_high;
   end

   // Read data stand for the one cycle after the strobe only
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         rdata_ff <= pfc_pkg::RDATA_NONE;
      else
         rdata_ff <= nxt_rdata;
   end

   // Pad level; don't-care while the pad enable is low
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         pin_out_ff <= pfc_pkg::RST_PADS;
      else
         pin_out_ff <= nxt_pin_out;                                 // [RULE9]
   end

   // Pad enables registered so no decode glitch reaches a pin
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         pin_oe_ff <= pfc_pkg::RST_PADS;                            // [RULE5]
      else
         pin_oe_ff <= nxt_pin_oe;                                   // [RULE1]
   end

   // Pull-up enables; only ever on for input-mode pins
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         pull_up_ff <= pfc_pkg::RST_PADS;
      else
         pull_up_ff <= nxt_pull_up;                                 // [RULE2]
   end

   // Pull-down enables; never together with a pull-up on one pin
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         pull_dn_ff <= pfc_pkg::RST_PADS;
      else
         pull_dn_ff <= nxt_pull_dn;                                 // [RULE2]
   end

   assign o_rdata   = rdata_ff;
   assign o_pin_out = pin_out_ff;
   assign o_pin_oe  = pin_oe_ff;
   assign o_pull_up = pull_up_ff;
   assign o_pull_dn = pull_dn_ff;

endmodule : pfc_port

`default_nettype wire

// >>> tb/pfc_pads_model.sv
// Pad model: the external circuit on the eight port pins
`timescale 1ns/1ps
`default_nettype none
module pfc_pads_model
(
   // Pad controls from the port
   input  wire logic [7:0] i_out,
   input  wire logic [7:0] i_oe,
   input  wire logic [7:0] i_up,
   input  wire logic [7:0] i_dn,
   // External driver and resolved pin levels
   input  wire logic [7:0] i_ext_en,
   input  wire logic [7:0] i_ext,
   output logic      [7:0] o_lvl
);
   // Port drive wins, then the external driver, then the pulls; a floating
   // pin reads the inverse of the port's level, so no stale copy can pass
   assign o_lvl = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext)
                | (~i_oe & ~i_ext_en & (i_up | (~i_dn & ~i_out)));
endmodule : pfc_pads_model
`default_nettype wire

// >>> tb/pfc_port_checker.sv
// Checker: readback and pad control relations at the port's pins
`timescale 1ns/1ps
`default_nettype none
module pfc_port_checker
(
   // Clock, reset and register port
   input wire logic        i_clk,
   input wire logic        i_nrst,
   input wire logic [15:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic        i_wide,
   input wire logic [15:0] o_rdata,
   // Pad controls
   input wire logic [7:0]  o_pin_oe,
   input wire logic [7:0]  o_pull_up,
   input wire logic [7:0]  o_pull_dn
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // Write, one idle cycle, then a read of the same place and width
   sequence back_s(logic [15:0] a, logic w);
      i_wr && i_addr == a && i_wide == w ##2 i_rd && i_addr == a && i_wide == w;
   endsequence
   low_back_a: assert property (back_s(pfc_pkg::ADDR_CFG_LOW, 1'b0)
      |=> o_rdata[7:0] == $past(i_wdata[7:0], 3)) else $error("low readback");
   high_back_a: assert property (back_s(pfc_pkg::ADDR_CFG_HIGH, 1'b0)
      |=> o_rdata[7:0] == $past(i_wdata[7:0], 3)) else $error("high readback");
   word_back_a: assert property (back_s(pfc_pkg::ADDR_CFG_LOW, 1'b1)
      |=> o_rdata == $past(i_wdata, 3)) else $error("word readback");
   reset_pads_a: assert property ($rose(i_nrst)
      |-> (o_pin_oe | o_pull_up | o_pull_dn) == 8'h00) else $error("reset pads");
   pull_pair_a: assert property ((o_pull_up & o_pull_dn) == 8'h00)
      else $error("both pulls on");
   pull_out_a: assert property (((o_pull_up | o_pull_dn) & o_pin_oe) == 8'h00)
      else $error("pull on a driven pin");
   dir_in_a: assert property (i_wr && i_addr == pfc_pkg::ADDR_DIR &&
      i_wdata[7:0] == 8'hFF ##1 !i_wr |=> o_pin_oe == 8'h00) else $error("in");
   dir_out_a: assert property (i_wr && i_addr == pfc_pkg::ADDR_DIR &&
      i_wdata[7:0] == 8'h00 ##1 !i_wr |=> (o_pull_up | o_pull_dn) == 8'h00)
      else $error("pull in output mode");
endmodule : pfc_port_checker
bind pfc_port pfc_port_checker chk (.i_clk, .i_nrst, .i_addr, .i_wdata,
   .i_wr, .i_rd, .i_wide, .o_rdata, .o_pin_oe, .o_pull_up, .o_pull_dn);
`default_nettype wire

// >>> tb/test_pfc_port.sv
// Testbench: register access and pad behaviour of the pin port
`timescale 1ns/1ps
`default_nettype none
module test_pfc_port;
   logic        i_clk, i_nrst, i_wr, i_rd, i_wide;
   logic [15:0] i_addr, i_wdata, o_rdata, q;
   logic [7:0]  lvl, o_pin_out, o_pin_oe, o_pull_up, o_pull_dn, dir, ed;
   logic [31:0] ep, seen;
   logic [7:0]  dirs [4] = '{8'hF0, 8'h0F, 8'hFF, 8'h00};
   int          miscompares = 0, checks = 0, cyc = 0;
   localparam logic [7:0] EXT = 8'h18;
   pfc_port dut (.i_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .i_wide,
      .o_rdata, .i_pin_in(lvl), .o_pin_out, .o_pin_oe, .o_pull_up, .o_pull_dn);
   pfc_pads_model pads (.i_out(o_pin_out), .i_oe(o_pin_oe), .i_up(o_pull_up),
      .i_dn(o_pull_dn), .i_ext_en(dir & 8'h99), .i_ext(EXT), .o_lvl(lvl));
   // Pad state as {oe, driven level, pull up, pull down}
   assign seen = {o_pin_oe, o_pin_out & o_pin_oe, o_pull_up, o_pull_dn};
   // One access; read data are taken in the cycle after the strobe
   task automatic acc(input logic [15:0] a, d, input logic w, wd);
      @(posedge i_clk);
      {i_addr, i_wdata, i_wr, i_rd, i_wide} <= {a, d, w, ~w, wd};
      @(posedge i_clk);
      {i_wr, i_rd} <= 2'h0;
      #1 q = o_rdata;
   endtask : acc
   task automatic cmp(input string n, input logic [31:0] e, g);
      checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : cmp
   // Expected pad state of one pin from its code, direction and data
   function automatic logic [3:0] pad(input logic [1:0] c, input logic d, v);
      if (d)
         return {2'h0, c == 2'h2, c == 2'h1};
      case (c)
         2'h0: return 4'h0;
         2'h1: return {v, v, 2'h0};
         2'h2: return {~v, 1'b0, 2'h0};
         default: return {1'b1, v, 2'h0};
      endcase
   endfunction : pad
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // Hang guard, far above the roughly 70 cycles the run needs
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         miscompares++;
         wrap_up();
      end
   end
   // Pin n gets code n mod 4; each pass sets a direction and a data level
   initial
   begin
      {i_nrst, i_wr, i_rd, i_wide, i_addr, i_wdata, dir} = '0;
      repeat (3) @(posedge i_clk);
      i_nrst <= 1'b1;
      acc(pfc_pkg::ADDR_CFG_LOW, 16'h0000, 1'b0, 1'b1);
      cmp("reset", 32'h0, {q, seen[31:24], seen[15:8] | seen[7:0]});
      for (int i = 0; i < 4; i++)
      begin
         dir = dirs[i];
         acc(pfc_pkg::ADDR_DATA, {8'h00, {8{i[0]}}}, 1'b1, 1'b0);
         acc(pfc_pkg::ADDR_DIR, {8'h00, dir}, 1'b1, 1'b0);
         acc(pfc_pkg::ADDR_CFG_LOW, 16'hCCAA, 1'b1, 1'b1);
         acc(pfc_pkg::ADDR_CFG_LOW, 16'h0000, 1'b0, 1'b1);
         cmp("word", 32'hCCAA, q);
         acc(pfc_pkg::ADDR_CFG_HIGH, 16'h00CC, 1'b1, 1'b0);
         acc(pfc_pkg::ADDR_CFG_HIGH, 16'h0000, 1'b0, 1'b0);
         cmp("high", 32'hCC, q[7:0]);
         for (int n = 0; n < 8; n++)
         begin
            {ep[24+n], ep[16+n], ep[8+n], ep[n]} = pad(n[1:0], dir[n], i[0]);
            ed[n] = dir[n] ? (n[1] ^ n[0] ? n[1] : EXT[n]) : i[0];
         end
         cmp("pads", ep, seen);
         acc(pfc_pkg::ADDR_DATA, 16'h0000, 1'b0, 1'b0);
         cmp("data", ed, q[7:0]);
      end
      acc(pfc_pkg::ADDR_CFG_LOW, 16'hFF5A, 1'b1, 1'b0);
      acc(pfc_pkg::ADDR_CFG_LOW, 16'h0000, 1'b0, 1'b0);
      cmp("low byte", 32'h5A, q[7:0]);
      acc(pfc_pkg::ADDR_CFG_LOW, 16'h0000, 1'b0, 1'b1);
      cmp("word after byte", 32'hCC5A, q);
      @(posedge i_clk) #1 cmp("rdata drop", 32'h0, o_rdata);
      acc(16'hF27C, 16'hFFFF, 1'b1, 1'b0);
      acc(16'hF27C, 16'h0000, 1'b0, 1'b0);
      cmp("unmapped", 32'h0, q);
      wrap_up();
   end
endmodule : test_pfc_port
`default_nettype wire
